// ### rtl/dasm_defs.svh
// timing counts and field positions for the dram address and strobe mux
// assumes inclusion by bare name from the package and modules
`ifndef DASM_DEFS_SVH
`define DASM_DEFS_SVH
`define DASM_CLK_PERIOD_NS   100
`define DASM_ROW_TIME_NS     100
`define DASM_COL_TIME_NS     200
`define DASM_ROW_CYCLES      ((`DASM_ROW_TIME_NS + `DASM_CLK_PERIOD_NS - 1) / `DASM_CLK_PERIOD_NS)
`define DASM_COL_CYCLES      ((`DASM_COL_TIME_NS + `DASM_CLK_PERIOD_NS - 1) / `DASM_CLK_PERIOD_NS)
`define DASM_REG_LSB         1
`define DASM_REG_MSB         8
`define DASM_MEM_LSB         1
`define DASM_MEM_MSB         18
`define DASM_BANK_BIT        19
`define DASM_ROW_LSB         0
`define DASM_COL_LSB         9
`define DASM_MUX_W           9
`define DASM_REG_W           8
`endif

// ### rtl/dasm_pkg.sv
// types shared by the dram address and strobe mux
// assumes dasm_defs.svh on the include path
`include "dasm_defs.svh"
package dasm_pkg;
  typedef logic [`DASM_MUX_W-1:0] dasm_mux_t;
  typedef logic [`DASM_REG_W-1:0] dasm_reg_t;
  typedef enum logic [3:0] {
    DASM_IDLE = 4'h1,
    DASM_ROW  = 4'h2,
    DASM_COL  = 4'h4,
    DASM_DONE = 4'h8
  } dasm_phase_e;
  typedef struct packed {
    logic ras0_n;
    logic row_strobe_bank1_n_n;
    logic col_strobe_low_n_n;
    logic col_strobe_high_n_n;
  } dasm_strobes_s;
  typedef struct packed {
    logic        mem_sel;
    logic        reg_sel;
    logic        dma;
    logic        refresh;
    logic        bank_hi;
    logic        wr;
    logic        lds;
    logic        uds;
    logic [17:0] word_addr;
  } dasm_req_s;
endpackage

// ### rtl/dasm_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes a single clock; the first stage is read only by the second
`timescale 1ns/1ns
module dasm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle pin levels, so no false request follows reset
      meta_r <= rst_val;
      q      <= rst_val;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // dasm_sync

// ### rtl/dasm_addr_split.sv
// splits an 18-bit word address into row and column halves
// assumes combinational use inside the mux top
`timescale 1ns/1ns
`include "dasm_defs.svh"
module dasm_addr_split (
  input  wire logic [17:0]      word_addr,
  output dasm_pkg::dasm_mux_t   row_addr,
  output dasm_pkg::dasm_mux_t   col_addr
);
  assign row_addr = word_addr[`DASM_ROW_LSB +: `DASM_MUX_W];
  assign col_addr = word_addr[`DASM_COL_LSB +: `DASM_MUX_W];
endmodule // dasm_addr_split

// ### rtl/dasm_mux.sv
// dram address multiplexer and strobe generator of the dma address chip
// assumes cpu pins are asynchronous and dma requests come from same-clock logic
// Functional notes
// - register access drives address bits 1-8 out
// - memory access multiplexes cpu address bits 1-18
// - bit 19 picks upper or lower row strobe
// - strobe plus register select, memory select off, means register access
// - strobe plus memory select means memory access
// - cpu read/write honoured on memory access and on register reads
// - dram read/write driven for dma and cpu
// - nine-bit address, row phase then column phase
// - address bus driven only for cpu memory or dma
// - cpu byte strobes map to column strobes
// - low column strobe low byte, high upper
// - lower row strobe for bit19 low or dma
// - upper row strobe never on plain dma
// - dma cycle output low during dma, lower bank
// - refresh asserts both row strobes and dma output
// - dma asserts both column strobes except refresh
// - buffered data bus carries register and dma data
// - dma output asserted before staging dma cycle
`timescale 1ns/1ns
`include "dasm_defs.svh"
module dasm_mux #(
  parameter int ROW_CYC = `DASM_ROW_CYCLES,
  parameter int COL_CYC = `DASM_COL_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic [19:1] CPU_ADDR,
  input  wire logic        CPU_ADDR_STROBE_N,
  input  wire logic        REG_SPACE_SEL_N,
  input  wire logic        MEM_SPACE_SEL_N,
  input  wire logic        CPU_READ_WRITE,
  input  wire logic        CPU_LOW_BYTE_STROBE_N,
  input  wire logic        CPU_HIGH_BYTE_STROBE_N,
  input  wire logic        DMA_REQ,
  input  wire logic        DMA_REFRESH,
  input  wire logic        DMA_WRITE,
  input  wire logic [17:0] DMA_WORD_ADDR,
  input  wire logic [15:0] DMA_WDATA,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic [15:0] BUFFERED_DATA_BUS_IN,
  output logic      [15:0] BUFFERED_DATA_BUS_OUT,
  output logic             BUFFERED_DATA_BUS_OE_N,
  output logic      [15:0] CPU_WDATA,
  output logic             CPU_WDATA_VALID,
  output logic      [15:0] DMA_RDATA,
  output logic             DMA_RDATA_VALID,
  output logic             DMA_BUSY,
  output logic             REG_ACCESS,
  output logic      [7:0]  EXT_REG_SELECT_BUS,
  output logic      [8:0]  DRAM_MUX_ADDR,
  output logic             DRAM_MUX_ADDR_OE_N,
  output logic             DRAM_READ_WRITE,
  output logic             ROW_STROBE_BANK0_N,
  output logic             ROW_STROBE_BANK1_N,
  output logic             COL_STROBE_LOW_N,
  output logic             COL_STROBE_HIGH_N,
  output logic             DMA_CYCLE_ACTIVE_N
);
  localparam int CNT_W = 4;

  // cpu pins after two flip-flops
  logic [18:0] addr_s;
  logic [5:0]  ctl_s;
  logic [15:0] data_s;
  dasm_sync #(.W(19)) u_sync_addr (
    .clk     (MCLK),
    .rst     (RST),
    .d       (CPU_ADDR),
    .rst_val ('0),
    .q       (addr_s)
  );
  dasm_sync #(.W(22)) u_sync_ctl (
    .clk     (MCLK),
    .rst     (RST),
    .d       ({BUFFERED_DATA_BUS_IN, CPU_ADDR_STROBE_N, REG_SPACE_SEL_N,
                MEM_SPACE_SEL_N, CPU_READ_WRITE, CPU_LOW_BYTE_STROBE_N,
                CPU_HIGH_BYTE_STROBE_N}),
    .rst_val (22'h00003F),
    .q       ({data_s, ctl_s})
  );

  // active-high views of the synchronised controls
  logic as_a, rsel_a, msel_a, rw_s, lds_a, uds_a;
  assign as_a   = ~ctl_s[5];
  assign rsel_a = ~ctl_s[4];
  assign msel_a = ~ctl_s[3];
  assign rw_s   =  ctl_s[2];
  assign lds_a  = ~ctl_s[1];
  assign uds_a  = ~ctl_s[0];

  function automatic logic [CNT_W-1:0] cnt_of(input int n);
    cnt_of = CNT_W'((n < 1) ? 0 : n - 1);
  endfunction

  typedef struct packed {
    dasm_pkg::dasm_phase_e   phase;
    logic [CNT_W-1:0]        cnt;
    dasm_pkg::dasm_req_s     req;
    dasm_pkg::dasm_strobes_s stb;
    logic [8:0]              ma;
    logic                    ma_oe_n;
    logic                    drw;
    logic                    dma_n;
    logic [7:0]              rga;
    logic                    reg_acc;
    logic                    busy;
    logic [15:0]             bus_out;
    logic                    bus_oe_n;
    logic [15:0]             cpu_wd;
    logic                    cpu_wv;
    logic [15:0]             dma_rd;
    logic                    dma_rv;
    logic                    rd_pend;
  } dasm_state_s;

  localparam dasm_pkg::dasm_strobes_s STB_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1};

  dasm_state_s st_r, st_nxt;
  dasm_pkg::dasm_mux_t row_a, col_a;

  dasm_addr_split u_split (
    .word_addr (st_r.req.word_addr),
    .row_addr  (row_a),
    .col_addr  (col_a)
  );

  logic cpu_mem, cpu_reg;
  assign cpu_mem = as_a & msel_a;
  assign cpu_reg = as_a & rsel_a & ~msel_a;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.cpu_wv = 1'b0;
    st_nxt.dma_rv = 1'b0;
    st_nxt.rd_pend = 1'b0;
    // register space decode, independent of the dram sequence
    st_nxt.reg_acc = cpu_reg;
    st_nxt.rga     = cpu_reg ? addr_s[`DASM_REG_MSB-1:`DASM_REG_LSB-1] : 8'hFF;
    unique case (st_r.phase)
      dasm_pkg::DASM_IDLE: begin
        st_nxt.stb      = STB_IDLE;
        st_nxt.ma_oe_n  = 1'b1;
        st_nxt.drw      = 1'b1;
        st_nxt.bus_oe_n = 1'b1;
        st_nxt.busy     = 1'b0;
        st_nxt.dma_n    = 1'b1;
        if (DMA_REQ) begin
          // dma owns the bus ahead of any row strobe
          st_nxt.dma_n             = 1'b0;
          st_nxt.busy              = 1'b1;
          st_nxt.req               = '0;
          st_nxt.req.dma           = 1'b1;
          st_nxt.req.refresh       = DMA_REFRESH;
          st_nxt.req.wr            = DMA_WRITE & ~DMA_REFRESH;
          st_nxt.req.word_addr     = DMA_WORD_ADDR;
          st_nxt.phase             = dasm_pkg::DASM_ROW;
          st_nxt.cnt               = cnt_of(ROW_CYC);
        end else if (cpu_mem) begin
          st_nxt.busy          = 1'b1;
          st_nxt.req           = '0;
          st_nxt.req.mem_sel   = 1'b1;
          st_nxt.req.bank_hi   = addr_s[`DASM_BANK_BIT-1];
          st_nxt.req.wr        = ~rw_s;
          st_nxt.req.lds       = lds_a;
          st_nxt.req.uds       = uds_a;
          st_nxt.req.word_addr = addr_s[`DASM_MEM_MSB-1:`DASM_MEM_LSB-1];
          st_nxt.phase         = dasm_pkg::DASM_ROW;
          st_nxt.cnt           = cnt_of(ROW_CYC);
        end
      end
      dasm_pkg::DASM_ROW: begin
        st_nxt.ma      = row_a;
        st_nxt.ma_oe_n = 1'b0;
        st_nxt.drw     = ~st_r.req.wr;
        if (st_r.req.dma) begin
          st_nxt.stb.ras0_n = 1'b0;
          st_nxt.stb.row_strobe_bank1_n_n = ~st_r.req.refresh;
        end else begin
          st_nxt.stb.ras0_n = st_r.req.bank_hi;
          st_nxt.stb.row_strobe_bank1_n_n = ~st_r.req.bank_hi;
        end
        if (st_r.cnt == '0) begin
          st_nxt.phase = dasm_pkg::DASM_COL;
          st_nxt.cnt   = cnt_of(COL_CYC);
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      dasm_pkg::DASM_COL: begin
        if (!st_r.req.refresh) begin
          st_nxt.ma = col_a;
        end
        if (st_r.req.dma) begin
          st_nxt.stb.col_strobe_low_n_n = st_r.req.refresh;
          st_nxt.stb.col_strobe_high_n_n = st_r.req.refresh;
        end else begin
          st_nxt.stb.col_strobe_low_n_n = ~st_r.req.lds;
          st_nxt.stb.col_strobe_high_n_n = ~st_r.req.uds;
        end
        // data word on the buffered bus for dma writes
        if (st_r.req.dma && st_r.req.wr) begin
          st_nxt.bus_out  = DMA_WDATA;
          st_nxt.bus_oe_n = 1'b0;
        end
        if (st_r.cnt == '0) begin
          st_nxt.phase = dasm_pkg::DASM_DONE;
        end else begin
          st_nxt.cnt = st_r.cnt - 1'b1;
        end
      end
      dasm_pkg::DASM_DONE: begin
        // read data trails the column strobe by the two pin flip-flops
        if (st_r.req.dma && !st_r.req.wr && !st_r.req.refresh) begin
          st_nxt.rd_pend = 1'b1;
        end
        if (st_r.req.mem_sel && st_r.req.wr) begin
          st_nxt.cpu_wd = data_s;
          st_nxt.cpu_wv = 1'b1;
        end
        st_nxt.stb      = STB_IDLE;
        st_nxt.ma_oe_n  = 1'b1;
        st_nxt.bus_oe_n = 1'b1;
        st_nxt.dma_n    = 1'b1;
        // cpu cycle ends when its address strobe goes away
        if (st_r.req.dma || !cpu_mem) begin
          st_nxt.phase = dasm_pkg::DASM_IDLE;
          st_nxt.busy  = 1'b0;
        end
      end
    endcase
    if (st_r.rd_pend) begin
      st_nxt.dma_rd = data_s;
      st_nxt.dma_rv = 1'b1;
    end
    // register reads from the cpu use the buffered bus when idle
    if (cpu_reg && rw_s && st_r.phase == dasm_pkg::DASM_IDLE && !DMA_REQ) begin
      st_nxt.bus_out  = REG_WDATA;
      st_nxt.bus_oe_n = 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_r          <= '0;
      st_r.phase    <= dasm_pkg::DASM_IDLE;
      st_r.stb      <= STB_IDLE;
      st_r.ma_oe_n  <= 1'b1;
      st_r.drw      <= 1'b1;
      st_r.dma_n    <= 1'b1;
      st_r.rga      <= 8'hFF;
      st_r.bus_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign BUFFERED_DATA_BUS_OUT  = st_r.bus_out;
  assign BUFFERED_DATA_BUS_OE_N = st_r.bus_oe_n;
  assign CPU_WDATA              = st_r.cpu_wd;
  assign CPU_WDATA_VALID        = st_r.cpu_wv;
  assign DMA_RDATA              = st_r.dma_rd;
  assign DMA_RDATA_VALID        = st_r.dma_rv;
  assign DMA_BUSY               = st_r.busy;
  assign REG_ACCESS             = st_r.reg_acc;
  assign EXT_REG_SELECT_BUS     = st_r.rga;
  assign DRAM_MUX_ADDR          = st_r.ma;
  assign DRAM_MUX_ADDR_OE_N     = st_r.ma_oe_n;
  assign DRAM_READ_WRITE        = st_r.drw;
  assign ROW_STROBE_BANK0_N     = st_r.stb.ras0_n;
  assign ROW_STROBE_BANK1_N     = st_r.stb.row_strobe_bank1_n_n;
  assign COL_STROBE_LOW_N       = st_r.stb.col_strobe_low_n_n;
  assign COL_STROBE_HIGH_N      = st_r.stb.col_strobe_high_n_n;
  assign DMA_CYCLE_ACTIVE_N     = st_r.dma_n;
endmodule // dasm_mux

// ### test/dasm_mux_asserts.sv
// assertions on the ports of the dram address and strobe mux
// assumes a bind onto dasm_mux, which hands on its column count
`timescale 1ns/1ns
module dasm_chk #(
  parameter int COL_CYC = 2
) (
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       DMA_BUSY,
  input wire logic       REG_ACCESS,
  input wire logic [7:0] EXT_REG_SELECT_BUS,
  input wire logic       DRAM_MUX_ADDR_OE_N,
  input wire logic       ROW_STROBE_BANK0_N,
  input wire logic       ROW_STROBE_BANK1_N,
  input wire logic       COL_STROBE_LOW_N,
  input wire logic       COL_STROBE_HIGH_N,
  input wire logic       DMA_CYCLE_ACTIVE_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  logic [7:0] cas_cnt_r;
  // cycles the low column strobe has been held
  always_ff @(posedge MCLK) begin
    if (RST || COL_STROBE_LOW_N) cas_cnt_r <= 8'h00;
    else cas_cnt_r <= cas_cnt_r + 8'h01;
  end
  sequence s_flag; !DMA_CYCLE_ACTIVE_N && ROW_STROBE_BANK0_N; endsequence
  sequence s_row; !ROW_STROBE_BANK0_N; endsequence
  property p_stage; $fell(DMA_CYCLE_ACTIVE_N) |-> s_flag ##1 s_row; endproperty
  a_stage: assert property (p_stage) else $error("dma flag not ahead of row");
  property p_busy; !DMA_CYCLE_ACTIVE_N |-> DMA_BUSY; endproperty
  a_busy: assert property (p_busy) else $error("dma flag without busy");
  property p_bank1; !DMA_CYCLE_ACTIVE_N && !ROW_STROBE_BANK1_N |-> !ROW_STROBE_BANK0_N; endproperty
  a_bank1: assert property (p_bank1) else $error("upper row on plain dma");
  property p_rfcas;
    !DMA_CYCLE_ACTIVE_N && !ROW_STROBE_BANK1_N |-> COL_STROBE_LOW_N && COL_STROBE_HIGH_N;
  endproperty
  a_rfcas: assert property (p_rfcas) else $error("column strobe in refresh");
  property p_oe; !(ROW_STROBE_BANK0_N && ROW_STROBE_BANK1_N) |-> !DRAM_MUX_ADDR_OE_N; endproperty
  a_oe: assert property (p_oe) else $error("row strobe with address off");
  property p_first;
    $fell(COL_STROBE_LOW_N) |-> $past(ROW_STROBE_BANK0_N && ROW_STROBE_BANK1_N) == 1'h0;
  endproperty
  a_first: assert property (p_first) else $error("column before row");
  property p_clen; $rose(COL_STROBE_LOW_N) |-> cas_cnt_r == COL_CYC; endproperty
  a_clen: assert property (p_clen) else $error("column phase length");
  property p_ext; !REG_ACCESS |-> EXT_REG_SELECT_BUS == 8'hFF; endproperty
  a_ext: assert property (p_ext) else $error("select bus off idle");
endmodule // dasm_chk
bind dasm_mux dasm_chk #(.COL_CYC(COL_CYC)) u_chk (.MCLK, .RST, .DMA_BUSY, .REG_ACCESS,
  .EXT_REG_SELECT_BUS, .DRAM_MUX_ADDR_OE_N, .ROW_STROBE_BANK0_N, .ROW_STROBE_BANK1_N,
  .COL_STROBE_LOW_N, .COL_STROBE_HIGH_N, .DMA_CYCLE_ACTIVE_N);

// ### test/dasm_dram_model.sv
// behavioural dram array on the mux's address and strobes
// assumes registered strobes; data out only while a read column is open
`timescale 1ns/1ns
module dasm_dram_model (
  input  wire logic        clk,
  input  wire logic [8:0]  ma,
  input  wire logic        ras_n,
  input  wire logic        col_strobe_low_n_n,
  input  wire logic        col_strobe_high_n_n,
  input  wire logic        rw,
  input  wire logic [15:0] wd,
  output logic      [15:0] rd,
  output logic             drv
);
  logic [15:0] mem [0:262143];
  logic [8:0]  row_r;
  logic [15:0] last_r = 16'h0000;
  assign drv = !(col_strobe_low_n_n && col_strobe_high_n_n) && rw;
  // released bus flips every cycle
  assign rd = drv ? mem[{ma, row_r}] : ~last_r;
  always @(posedge clk) begin
    last_r <= rd;
    if (!ras_n && col_strobe_low_n_n && col_strobe_high_n_n) row_r <= ma;
    if (!rw && !col_strobe_low_n_n) mem[{ma, row_r}][7:0] <= wd[7:0];
    if (!rw && !col_strobe_high_n_n) mem[{ma, row_r}][15:8] <= wd[15:8];
  end
endmodule // dasm_dram_model

// ### test/tb.sv
// self-checking bench for the dram address and strobe mux
// assumes dasm_mux, its checker and the dram model compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
`define WT(c) begin n = 0; while (!(c) && n < 40) begin @(negedge mclk); n++; end end
module tb;
  logic mclk = 1'h0, rst = 1'h1, as_n = 1'h1, rs_n = 1'h1, ms_n = 1'h1, crw = 1'h1;
  logic lds_n = 1'h1, uds_n = 1'h1, dreq = 1'h0, dref = 1'h0, dwr = 1'h0;
  logic [19:1] addr = '0;
  logic [17:0] dadr = '0;
  logic [15:0] dwd = '0, bout, rdat, mq, cwd;
  logic [7:0]  ext;
  logic [8:0]  ma;
  logic        rval, busy, racc, ma_oe_n, dram_read_write, r0, r1, cl, ch, dma_n, drv, boe, cwv;
  int          n, mismatches = 0, comparisons = 0;
  always #50 mclk = ~mclk;
  dasm_mux #(.ROW_CYC(1), .COL_CYC(2)) dut (
    .MCLK(mclk), .RST(rst), .CPU_ADDR(addr), .CPU_ADDR_STROBE_N(as_n), .REG_SPACE_SEL_N(rs_n),
    .MEM_SPACE_SEL_N(ms_n), .CPU_READ_WRITE(crw), .CPU_LOW_BYTE_STROBE_N(lds_n),
    .CPU_HIGH_BYTE_STROBE_N(uds_n), .DMA_REQ(dreq), .DMA_REFRESH(dref), .DMA_WRITE(dwr),
    .DMA_WORD_ADDR(dadr), .DMA_WDATA(dwd), .REG_WDATA(16'h5AA5),
    .BUFFERED_DATA_BUS_IN(drv ? mq : 16'h3C3C), .BUFFERED_DATA_BUS_OUT(bout),
    .BUFFERED_DATA_BUS_OE_N(boe), .CPU_WDATA(cwd), .CPU_WDATA_VALID(cwv), .DMA_RDATA(rdat),
    .DMA_RDATA_VALID(rval), .DMA_BUSY(busy), .REG_ACCESS(racc), .EXT_REG_SELECT_BUS(ext),
    .DRAM_MUX_ADDR(ma), .DRAM_MUX_ADDR_OE_N(ma_oe_n), .DRAM_READ_WRITE(dram_read_write),
    .ROW_STROBE_BANK0_N(r0), .ROW_STROBE_BANK1_N(r1), .COL_STROBE_LOW_N(cl),
    .COL_STROBE_HIGH_N(ch), .DMA_CYCLE_ACTIVE_N(dma_n));
  dasm_dram_model ram (.clk(mclk), .ma(ma), .ras_n(r0 & r1), .col_strobe_low_n_n(cl), .col_strobe_high_n_n(ch),
    .rw(dram_read_write), .wd(bout), .rd(mq), .drv(drv));
  task automatic dma(input logic wr, input logic rf, input logic [17:0] a, input logic [15:0] d);
    dreq = 1'h1; dwr = wr; dref = rf; dadr = a; dwd = d;
    @(negedge mclk);
    dreq = 1'h0;
    `WT(!r0)
    `CHK({r0, r1, dma_n}, {1'h0, !rf, 1'h0})
    `CHK(ma, a[8:0])
    `CHK(dram_read_write, !wr)
    if (!rf) begin
      `WT(!cl)
      `CHK({cl, ch, boe, ma}, {2'h0, !wr, a[17:9]})
    end
    `WT(dma_n)
    if (!wr && !rf) begin
      `WT(rval)
      `CHK({rval, rdat}, {1'h1, d})
    end
    `WT(!busy)
    @(negedge mclk);
  endtask
  task automatic test_dma;
    dma(1'h1, 1'h0, 18'h2D0F3, 16'hA55A);
    dma(1'h0, 1'h0, 18'h2D0F3, 16'hA55A);
    dma(1'h0, 1'h1, 18'h00123, 16'h0000);
    $display("test dma done");
  endtask
  task automatic test_cpu;
    for (int i = 1; i < 4; i++) begin
      addr = {i[0], 18'h1B2C4 ^ 18'(i)}; crw = i[1]; lds_n = !i[0]; uds_n = !i[1];
      as_n = 1'h0; ms_n = 1'h0;
      `WT(!(r0 & r1))
      `CHK({r1, r0}, i[0] ? 2'h1 : 2'h2)
      `CHK({ma_oe_n, dram_read_write, ma}, {1'h0, crw, addr[9:1]})
      `WT(!(cl & ch))
      `CHK({ch, cl, ma}, {~i[1:0], addr[18:10]})
      as_n = 1'h1; ms_n = 1'h1; lds_n = 1'h1; uds_n = 1'h1;
      `WT(ma_oe_n)
      `CHK({ma_oe_n, r0, r1, cl, ch}, 5'h1F)
      `CHK(cwv, !crw)
      if (!crw) `CHK(cwd, 16'h3C3C)
      repeat (3) @(negedge mclk);
    end
    $display("test cpu done");
  endtask
  task automatic test_reg;
    addr = {11'h4C1, 8'hA5}; as_n = 1'h0; rs_n = 1'h0; crw = 1'h1;
    `WT(racc)
    `CHK({racc, ext, ma_oe_n, r0, r1, boe, bout}, {1'h1, 8'hA5, 3'h7, 1'h0, 16'h5AA5})
    as_n = 1'h1; rs_n = 1'h1;
    `WT(!racc)
    `CHK({ext, boe}, {8'hFF, 1'h1})
    ms_n = 1'h0;
    repeat (5) @(negedge mclk);
    `CHK({ma_oe_n, r0, r1}, 3'h7)
    ms_n = 1'h1;
    $display("test reg done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'h0;
    repeat (2) @(negedge mclk);
    test_dma;
    test_cpu;
    test_reg;
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule // tb
